//--- pkg/duh_pkg.sv
// Shared constants of the dual serial host front end
package duh_pkg;

   // Register offsets inside one channel
   localparam logic [2:0] MCR_OFFSET      = 3'h4;

   // Modem control register fields and reset value
   localparam int         MCR_IRQ_GATE_BIT  = 3;
   localparam int         MCR_PRESCALE_BIT  = 7;
   localparam logic [7:0] MCR_RESET         = 8'h00;

   // Prescaler divide ratios
   localparam int         PRESC_DIV1 = 1;
   localparam int         PRESC_DIV4 = 4;
   localparam int         PRESC_CNT_W = 2;

   // Buffer depth of each direction of a channel
   localparam int         FIFO_DEPTH = 32;

   // Reset pulse qualification
   localparam int         CLK_PERIOD_NS = 4;
   localparam int         RST_MIN_NS    = 40;
   localparam int         RST_MIN_CYC   =
      (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int         RST_CNT_W     = 4;

   // Channel reset sequencer
   typedef enum logic [1:0] {
      RST_IDLE   = 2'b00,
      RST_QUAL   = 2'b01,
      RST_ACTIVE = 2'b10
   } duh_rst_state_t;

endpackage

//--- hdl/duh_host_front.sv
`timescale 1ns/1ps
module duh_host_front #(
   parameter int DEPTH = duh_pkg::FIFO_DEPTH,
   parameter int LVL_W = $clog2(duh_pkg::FIFO_DEPTH + 1)
) (
   // Clock and power-up reset
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   // Device straps and control pins
   input  wire logic             busModeSel,
   input  wire logic             resetPin,
   input  wire logic             bus_isolate_input,
   input  wire logic             prescale_select_pin,
   // Host bus
   input  wire logic             read_strobe_n,
   input  wire logic             write_strobe_n,
   input  wire logic             chan_a_select_n,
   input  wire logic             chan_b_select_n,
   input  wire logic             chan_address_bit,
   input  wire logic [2:0]       hostAddr,
   input  wire logic [7:0]       hostDataIn,
   output logic      [7:0]       hostDataOut,
   output logic                  hostDataOe_n,
   // Register strobes toward the channels
   output logic                  regRdA,
   output logic                  regWrA,
   output logic                  regRdB,
   output logic                  regWrB,
   input  wire logic [7:0]       chanRdDataA,
   input  wire logic [7:0]       chanRdDataB,
   // Channel reset and baud timing
   output logic                  chanReset,
   output logic                  baudTickA,
   output logic                  baudTickB,
   output logic                  prescaleDiv4A,
   output logic                  prescaleDiv4B,
   // Buffer levels and flags
   input  wire logic [LVL_W-1:0] txLevelA,
   input  wire logic [LVL_W-1:0] txLevelB,
   input  wire logic [LVL_W-1:0] rxLevelA,
   input  wire logic [LVL_W-1:0] rxLevelB,
   output logic                  bufFullTxA,
   output logic                  bufFullTxB,
   output logic                  bufFullRxA,
   output logic                  bufFullRxB,
   // Serial pins
   input  wire logic             chanTxA,
   input  wire logic             chanTxB,
   output logic                  txPinA,
   output logic                  txPinB,
   input  wire logic             rxPinA,
   input  wire logic             rxPinB,
   output logic                  chanRxA,
   output logic                  chanRxB,
   // Interrupt and auxiliary pins
   input  wire logic             chanIrqA,
   input  wire logic             chanIrqB,
   output logic                  irq_chan_a,
   output logic                  irq_chan_a_oe_n,
   output logic                  irq_chan_b,
   output logic                  irq_chan_b_oe_n,
   output logic                  aux_out2_chan_a_n,
   output logic                  aux_out2_chan_b_n
);

   // Channel select decode from the bus pins
   function automatic logic [1:0] decodeSel(
      input logic strobeMode,
      input logic csA_n,
      input logic csB_n,
      input logic addrBit
   );
      logic [1:0] sel;
      sel = 2'b00;
      if (strobeMode) begin
         sel = {~csB_n, ~csA_n};
      end else if (!csA_n) begin
         sel = addrBit ? 2'b10 : 2'b01;
      end
      return sel;
   endfunction

   // Reset sequencer state
   duh_pkg::duh_rst_state_t          rstState_reg;
   duh_pkg::duh_rst_state_t          rstState_next;
   logic [duh_pkg::RST_CNT_W-1:0]    rstCnt_reg;
   logic [duh_pkg::RST_CNT_W-1:0]    rstCnt_next;
   logic                             pinRstActive;

   // Bus decode
   logic [1:0]                       chanSel;
   logic                             busRead;
   logic                             busWrite;
   logic [1:0]                       rdCh;
   logic [1:0]                       wrCh;

   // Per-channel state
   logic [7:0]                       mcr_reg     [0:1];
   logic [7:0]                       mcr_next    [0:1];
   logic [1:0]                       wrSeen_reg;
   logic [1:0]                       wrSeen_next;
   logic [1:0]                       div4_reg;
   logic [1:0]                       div4_next;
   logic [duh_pkg::PRESC_CNT_W-1:0]  divCnt_reg  [0:1];
   logic [duh_pkg::PRESC_CNT_W-1:0]  divCnt_next [0:1];
   logic [1:0]                       tick;

   // Read data path
   logic [7:0]                       rdData_reg;
   logic [7:0]                       rdData_next;

   // Reset pin polarity follows the bus mode
   assign pinRstActive = busModeSel ? resetPin : ~resetPin;

   // Reset qualification next state
   always_comb begin
      rstState_next = rstState_reg;
      rstCnt_next   = rstCnt_reg;
      case (rstState_reg)
         duh_pkg::RST_IDLE: begin
            rstCnt_next = '0;
            if (pinRstActive) begin
               rstState_next = duh_pkg::RST_QUAL;
               rstCnt_next   = duh_pkg::RST_CNT_W'(1);
            end
         end
         duh_pkg::RST_QUAL: begin
            if (!pinRstActive) begin
               rstState_next = duh_pkg::RST_IDLE;
               rstCnt_next   = '0;
            end else if (rstCnt_reg >=
                         duh_pkg::RST_CNT_W'(duh_pkg::RST_MIN_CYC - 1)) begin
               rstState_next = duh_pkg::RST_ACTIVE;
            end else begin
               rstCnt_next = rstCnt_reg + duh_pkg::RST_CNT_W'(1);
            end
         end
         duh_pkg::RST_ACTIVE: begin
            rstCnt_next = '0;
            if (!pinRstActive) begin
               rstState_next = duh_pkg::RST_IDLE;
            end
         end
         default: begin
            rstState_next = duh_pkg::RST_ACTIVE;
            rstCnt_next   = '0;
         end
      endcase
   end

   // Reset qualification registers
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rstState_reg <= duh_pkg::RST_ACTIVE;
         rstCnt_reg   <= '0;
      end else begin
         rstState_reg <= rstState_next;
         rstCnt_reg   <= rstCnt_next;
      end
   end

   // Single registered reset for both channels
   assign chanReset = (rstState_reg == duh_pkg::RST_ACTIVE);

   // Host bus decode, gated by isolation and reset
   always_comb begin
      chanSel = decodeSel(busModeSel, chan_a_select_n,
                          chan_b_select_n, chan_address_bit);
      if (busModeSel) begin
         busRead  = ~read_strobe_n;
         busWrite = ~write_strobe_n;
      end else begin
         busRead  = write_strobe_n;                  // Direction high reads
         busWrite = ~write_strobe_n;
      end
      if (bus_isolate_input || chanReset) begin
         chanSel = 2'b00;
      end
      rdCh = chanSel & {2{busRead}};
      wrCh = chanSel & {2{busWrite}};
   end

   // Strobes toward the channel register files
   assign regRdA = rdCh[0];
   assign regRdB = rdCh[1];
   assign regWrA = wrCh[0];
   assign regWrB = wrCh[1];

   // Per-channel control state, one copy each
   for (genvar ch = 0; ch < 2; ch++) begin : g_chan

      // Next control values of this channel
      always_comb begin
         mcr_next[ch]    = mcr_reg[ch];
         wrSeen_next[ch] = wrCh[ch];
         div4_next[ch]   = div4_reg[ch];
         divCnt_next[ch] = divCnt_reg[ch] +
                           duh_pkg::PRESC_CNT_W'(1);
         if (chanReset) begin
            mcr_next[ch]    = duh_pkg::MCR_RESET;
            div4_next[ch]   = ~prescale_select_pin;
            divCnt_next[ch] = '0;
         end else if (wrCh[ch] && !wrSeen_reg[ch] &&
                      hostAddr == duh_pkg::MCR_OFFSET) begin
            mcr_next[ch]  = hostDataIn;
            div4_next[ch] =
               hostDataIn[duh_pkg::MCR_PRESCALE_BIT];
         end
         if (!div4_reg[ch]) begin
            divCnt_next[ch] = '0;
         end
      end

      // Control registers of this channel
      always_ff @(posedge clk_sys or negedge rst_n) begin
         if (!rst_n) begin
            mcr_reg[ch]    <= duh_pkg::MCR_RESET;
            wrSeen_reg[ch] <= 1'b0;
            div4_reg[ch]   <= 1'b0;
            divCnt_reg[ch] <= '0;
         end else begin
            mcr_reg[ch]    <= mcr_next[ch];
            wrSeen_reg[ch] <= wrSeen_next[ch];
            div4_reg[ch]   <= div4_next[ch];
            divCnt_reg[ch] <= divCnt_next[ch];
         end
      end

      // Baud tick: every cycle or every fourth
      assign tick[ch] = !chanReset &&
         (!div4_reg[ch] ||
          divCnt_reg[ch] ==
          duh_pkg::PRESC_CNT_W'(duh_pkg::PRESC_DIV4 - 1));
   end

   // Read data capture from the selected channel
   always_comb begin
      rdData_next = rdData_reg;
      if (rdCh[0]) begin
         rdData_next = (hostAddr == duh_pkg::MCR_OFFSET) ?
                       mcr_reg[0] : chanRdDataA;
      end else if (rdCh[1]) begin
         rdData_next = (hostAddr == duh_pkg::MCR_OFFSET) ?
                       mcr_reg[1] : chanRdDataB;
      end
   end

   // Read data register
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rdData_reg <= 8'h00;
      end else begin
         rdData_reg <= rdData_next;
      end
   end

   // Host data bus drive
   assign hostDataOut  = rdData_reg;
   assign hostDataOe_n = ~(|rdCh);

   // Prescale and baud outputs
   assign baudTickA     = tick[0];
   assign baudTickB     = tick[1];
   assign prescaleDiv4A = div4_reg[0];
   assign prescaleDiv4B = div4_reg[1];

   // Buffer full flags at the documented depth
   assign bufFullTxA = (txLevelA == LVL_W'(DEPTH));
   assign bufFullTxB = (txLevelB == LVL_W'(DEPTH));
   assign bufFullRxA = (rxLevelA == LVL_W'(DEPTH));
   assign bufFullRxB = (rxLevelB == LVL_W'(DEPTH));

   // Serial pins forced idle during reset
   assign txPinA  = chanReset ? 1'b1 : chanTxA;
   assign txPinB  = chanReset ? 1'b1 : chanTxB;
   assign chanRxA = chanReset ? 1'b1 : rxPinA;
   assign chanRxB = chanReset ? 1'b1 : rxPinB;

   // Interrupt pins gated by output-2 bits
   assign irq_chan_a      = chanIrqA;
   assign irq_chan_b      = chanIrqB;
   assign irq_chan_a_oe_n =
      ~mcr_reg[0][duh_pkg::MCR_IRQ_GATE_BIT];
   assign irq_chan_b_oe_n =
      ~mcr_reg[1][duh_pkg::MCR_IRQ_GATE_BIT];
   assign aux_out2_chan_a_n =
      ~mcr_reg[0][duh_pkg::MCR_IRQ_GATE_BIT];
   assign aux_out2_chan_b_n =
      ~mcr_reg[1][duh_pkg::MCR_IRQ_GATE_BIT];

endmodule // duh_host_front

//--- testbench/duh_host_front_checker.sv
`timescale 1ns/1ps
module duh_host_front_checker #(
   parameter int DEPTH = 32,
   parameter int LVL_W = 6
) (
   // Clock, reset and straps
   input logic             clk_sys, rst_n, busModeSel, resetPin,
   input logic             bus_isolate_input, prescale_select_pin,
   // Host bus
   input logic             read_strobe_n, write_strobe_n, chan_a_select_n,
   input logic             chan_b_select_n, chan_address_bit, hostDataOe_n,
   input logic [2:0]       hostAddr,
   input logic [7:0]       hostDataIn,
   input logic             regRdA, regWrA, regRdB, regWrB,
   // Channel side
   input logic             chanReset, baudTickA, prescaleDiv4A, bufFullTxA,
   input logic [LVL_W-1:0] txLevelA,
   input logic             txPinA, txPinB, chanRxA, chanRxB,
   input logic             irq_chan_a_oe_n, aux_out2_chan_a_n
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // Bus open to the host, and a decoded write to channel A
   wire logic open = !bus_isolate_input && !chanReset;
   wire logic wrA = open && !write_strobe_n && !chan_a_select_n
                    && (busModeSel || !chan_address_bit);
   // Steps of a pin reset and of a control register write
   sequence pinActive;
      resetPin == busModeSel;
   endsequence
   sequence mcrWrA;
      wrA && $past(write_strobe_n) && hostAddr == duh_pkg::MCR_OFFSET;
   endsequence
   mcr_write_a: assert property (
      mcrWrA |=> aux_out2_chan_a_n == !$past(hostDataIn[3])
      && irq_chan_a_oe_n == aux_out2_chan_a_n
      && prescaleDiv4A == $past(hostDataIn[7]))
      else $error("control write not applied");
   tx_hold_a: assert property (
      chanReset |-> txPinA && txPinB && chanRxA && chanRxB)
      else $error("serial lines not idle in reset");
   bus_isolate_a: assert property (
      bus_isolate_input |-> !(regRdA || regWrA || regRdB || regWrB)
      && hostDataOe_n)
      else $error("bus active while isolated");
   strobe_select_a: assert property (
      busModeSel && open && !read_strobe_n && chan_a_select_n
      && !chan_b_select_n |-> regRdB && !regRdA && !hostDataOe_n)
      else $error("strobe mode select wrong");
   cs_select_a: assert property (
      !busModeSel && open && !chan_a_select_n && write_strobe_n
      |-> regRdB == chan_address_bit && regRdA == !chan_address_bit)
      else $error("chip select mode decode wrong");
   reset_qual_a: assert property (
      pinActive [*5] ##1 pinActive [*5] |-> ##[1:2] chanReset)
      else $error("long reset pulse not taken");
   reset_end_a: assert property (
      chanReset && !(resetPin == busModeSel) |=> !chanReset)
      else $error("channel reset not released");
   presc_sample_a: assert property (
      $fell(chanReset) |-> prescaleDiv4A == !$past(prescale_select_pin))
      else $error("prescaler not sampled");
   presc_hold_a: assert property (
      !chanReset && !$past(chanReset) && !$past(wrA) |-> $stable(prescaleDiv4A))
      else $error("prescaler changed without write");
   baud_div1_a: assert property (
      !chanReset && !$past(chanReset) && !prescaleDiv4A
      && !$past(prescaleDiv4A) |-> baudTickA)
      else $error("missing tick at divide by 1");
   buf_full_a: assert property (
      bufFullTxA == (txLevelA == DEPTH))
      else $error("buffer full flag wrong");
endmodule // duh_host_front_checker
bind duh_host_front duh_host_front_checker #(.DEPTH(DEPTH), .LVL_W(LVL_W))
   chk (.*);

//--- testbench/duh_host_model.sv
`timescale 1ns/1ps
// Host processor on the byte-wide register bus
module duh_host_model (
   input  logic       clk_sys, busModeSel,
   output logic       read_strobe_n, write_strobe_n, chan_a_select_n,
   output logic       chan_b_select_n, chan_address_bit,
   output logic [2:0] hostAddr,
   output logic [7:0] hostDataIn
);
   // Strobes and selects go high; address, data and channel bit show the inverse of their last value
   task automatic idle();
      read_strobe_n = 1'b1;
      write_strobe_n = 1'b1;
      chan_a_select_n = 1'b1;
      chan_b_select_n = 1'b1;
      hostAddr = ~hostAddr;
      hostDataIn = ~hostDataIn;
      chan_address_bit = ~chan_address_bit;
   endtask
   initial begin
      {hostAddr, hostDataIn, chan_address_bit} = '0;
      idle();
   end
   // One access held over one edge; output-2 written only on purpose
   task automatic access(input logic wr, chB, input logic [2:0] a,
                         input logic [7:0] d);
      @(posedge clk_sys);
      #1;
      hostAddr = a;
      hostDataIn = d;
      chan_address_bit = chB;
      write_strobe_n = !wr;
      if (busModeSel) begin
         read_strobe_n = wr;
         chan_a_select_n = chB;
         chan_b_select_n = !chB;
      end else begin
         chan_a_select_n = 1'b0;
      end
      @(posedge clk_sys);
      #1;
      idle();
   endtask
endmodule // duh_host_model

//--- testbench/duh_host_front_test.sv
`timescale 1ns/1ps
module duh_host_front_test;
   localparam int DEPTH = 32;
   localparam int LVL_W = 6;
   logic             clk_sys, rst_n, busModeSel, resetPin, bus_isolate_input;
   logic             prescale_select_pin, read_strobe_n, write_strobe_n;
   logic             chan_a_select_n, chan_b_select_n, chan_address_bit;
   logic [2:0]       hostAddr;
   logic [7:0]       hostDataIn, hostDataOut, chanRdDataA, chanRdDataB;
   logic             hostDataOe_n, regRdA, regWrA, regRdB, regWrB, chanReset;
   logic             baudTickA, baudTickB, prescaleDiv4A, prescaleDiv4B;
   logic [LVL_W-1:0] txLevelA, txLevelB, rxLevelA, rxLevelB;
   logic             bufFullTxA, bufFullTxB, bufFullRxA, bufFullRxB;
   logic             chanTxA, chanTxB, txPinA, txPinB, rxPinA, rxPinB;
   logic             chanRxA, chanRxB, chanIrqA, chanIrqB, irq_chan_a;
   logic             irq_chan_a_oe_n, irq_chan_b, irq_chan_b_oe_n;
   logic             aux_out2_chan_a_n, aux_out2_chan_b_n, rdSeen;
   logic [2:0]       expA, expB;
   logic [7:0]       expQ[$];
   int               failures, totalChecks;
   wire logic [2:0]  seenA = {aux_out2_chan_a_n, irq_chan_a_oe_n, prescaleDiv4A};
   wire logic [2:0]  seenB = {aux_out2_chan_b_n, irq_chan_b_oe_n, prescaleDiv4B};
   duh_host_front #(.DEPTH(DEPTH), .LVL_W(LVL_W)) dut (.*);
   duh_host_model host (.*);
   // Clock
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   task automatic check(input string what, input logic [7:0] seen, exp);
      totalChecks++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic finish_test();
      if (failures == 0 && totalChecks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Aux, interrupt enable and divider of both channels
   task automatic pins();
      check("chanA", {5'h00, seenA}, {5'h00, expA});
      check("chanB", {5'h00, seenB}, {5'h00, expB});
   endtask
   task automatic mcrWrite(input logic chB, input logic [7:0] d);
      host.access(1'b1, chB, duh_pkg::MCR_OFFSET, d);
      if (!bus_isolate_input && chB)
         expB = {!d[3], !d[3], d[7]};
      else if (!bus_isolate_input)
         expA = {!d[3], !d[3], d[7]};
      pins();
   endtask
   // Read with a note for the monitor
   task automatic rdReg(input logic chB);
      chanRdDataA = 8'($urandom);
      chanRdDataB = 8'($urandom);
      expQ.push_back(chB ? chanRdDataB : chanRdDataA);
      host.access(1'b0, chB, 3'h0, 8'h00);
   endtask
   // Reset pin pulse; long ones are held past the minimum
   task automatic pinReset(input int len, input logic psel);
      @(posedge clk_sys);
      #1;
      prescale_select_pin = psel;
      resetPin = busModeSel;
      repeat (len) @(posedge clk_sys);
      #1;
      resetPin = !busModeSel;
      repeat (2) @(posedge clk_sys);
      #1;
      prescale_select_pin = !psel;
      @(posedge clk_sys);
      #1;
      if (len > duh_pkg::RST_MIN_CYC) begin
         expA = {2'b11, !psel};
         expB = {2'b11, !psel};
      end
      pins();
   endtask
   // Read results are compared the edge after the read
   always @(posedge clk_sys) begin
      if (rdSeen && expQ.size() > 0)
         check("readData", hostDataOut, expQ.pop_front());
      rdSeen = (hostDataOe_n === 1'b0);
   end
   // Random channel side traffic, buffer flag, interrupt and transmit outputs checked before each change
   always @(posedge clk_sys) begin
      #1;
      check("bufFull", {4'h0, bufFullTxA, bufFullTxB, bufFullRxA, bufFullRxB},
            {4'h0, txLevelA == DEPTH, txLevelB == DEPTH,
             rxLevelA == DEPTH, rxLevelB == DEPTH});
      check("irqPins", {6'h00, irq_chan_a, irq_chan_b},
            {6'h00, chanIrqA, chanIrqB});
      check("txPins", {6'h00, txPinA, txPinB},
            {6'h00, chanReset ? 2'b11 : {chanTxA, chanTxB}});
      {chanTxA, chanTxB, rxPinA, rxPinB, chanIrqA, chanIrqB} = 6'($urandom);
      txLevelA = LVL_W'($urandom_range(DEPTH, DEPTH - 2));
      txLevelB = LVL_W'($urandom_range(DEPTH, DEPTH - 2));
      rxLevelA = LVL_W'($urandom_range(DEPTH, DEPTH - 2));
      rxLevelB = LVL_W'($urandom_range(DEPTH, DEPTH - 2));
   end
   // Watchdog
   initial begin
      #20000;
      failures++;
      finish_test();
   end
   // Main sequence
   initial begin
      void'($urandom(5677));
      {busModeSel, resetPin, bus_isolate_input, prescale_select_pin} = 4'b1000;
      {chanTxA, chanTxB, rxPinA, rxPinB, chanIrqA, chanIrqB} = 6'h3f;
      {txLevelA, txLevelB, rxLevelA, rxLevelB} = '0;
      {chanRdDataA, chanRdDataB, rdSeen} = '0;
      {failures, totalChecks} = '0;
      rst_n = 1'b0;
      expA = 3'b111;
      expB = 3'b111;
      repeat (3) @(posedge clk_sys);
      #1;
      rst_n = 1'b1;
      repeat (2) @(posedge clk_sys);
      #1;
      pins();
      for (int m = 1; m >= 0; m--) begin
         busModeSel = m[0];
         resetPin = !m[0];
         pinReset(5, 1'b1);
         pinReset(12, m[0]);
         for (int i = 0; i < 8; i++) begin
            mcrWrite(i[0], 8'($urandom));
            rdReg(i[1]);
         end
         bus_isolate_input = 1'b1;
         mcrWrite(1'b0, {~seenA[0], 3'h0, seenA[2], 3'h0});
         bus_isolate_input = 1'b0;
      end
      repeat (2) @(posedge clk_sys);
      check("pendingReads", 8'(expQ.size()), 8'h00);
      finish_test();
   end
endmodule // duh_host_front_test
